// file: hw/avsp_app_end.sv
// Purpose: application end of the stream port, source or sink
// Assumes: user ports on av_clk_in except clk_drive_in
// Notes:   source ready follows the pin; sink must take every pulse
`timescale 1ns/1ps
`include "avsp_defines.svh"
module avsp_app_end (
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   av_clk_in,
  avsp_port_if.app                    port_if,
  input  wire logic                   clk_drive_in,
  input  wire logic                   sink_mode_in,
  input  wire logic                   src_valid_in,
  input  wire avsp_pkg::avsp_tx_word_t src_word_in,
  output logic                        src_ready_out,
  input  wire logic                   frame_mark_in,
  output logic                        sink_valid_out,
  output avsp_pkg::avsp_rx_word_t     sink_word_out,
  input  wire logic                   sink_ready_in,
  output logic                        frame_sync_out
);
  import avsp_pkg::*;

  logic       clk_q, clk_oe_q;
  logic [3:0] div_q;
  wire        div_end = (div_q == `AVSP_CLK_HALF - 4'h1);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_q    <= 1'b0;
      clk_oe_q <= 1'b0;
      div_q    <= 4'h0;
    end else begin
      clk_oe_q <= clk_drive_in;
      div_q    <= div_end ? 4'h0 : div_q + 4'h1;
      if (div_end) clk_q <= ~clk_q;
    end
  end

  logic [7:0]    d_q;
  logic          v_q, s_q, e_q, sy_q, fs_q, rdy_q;
  logic          sv_q, fso_q;
  avsp_rx_word_t sw_q;

  // ready is the device's own flop on this clock, so no sync needed
  wire load = ~sink_mode_in & src_valid_in & port_if.accept_ready;
  wire got  = sink_mode_in & port_if.byte_valid;

  always_ff @(posedge av_clk_in or posedge rst_in) begin
    if (rst_in) begin
      d_q  <= 8'h00;
      v_q  <= 1'b0;
      s_q  <= 1'b0;
      e_q  <= 1'b0;
      sy_q <= 1'b0;
      fs_q <= 1'b0;
    end else begin
      v_q  <= load;
      fs_q <= ~sink_mode_in & frame_mark_in;
      if (load) begin
        d_q  <= src_word_in.data;
        s_q  <= src_word_in.sop;
        e_q  <= src_word_in.eop;
        sy_q <= src_word_in.sy;
      end else begin
        // start may only show beside valid, so it drops with it
        s_q  <= 1'b0;
        e_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge av_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_q <= 1'b0;
      sv_q  <= 1'b0;
      sw_q  <= '0;
      fso_q <= 1'b0;
    end else begin
      rdy_q <= sink_mode_in & sink_ready_in;
      sv_q  <= got;
      fso_q <= sink_mode_in & port_if.frame_sync_pin;
      if (got) begin
        sw_q.data    <= port_if.av_byte_bus;
        sw_q.sop     <= port_if.packet_start;
        sw_q.crc_err <= port_if.crc_error_flag;
        sw_q.seq_err <= port_if.sequence_loss_flag;
        sw_q.sy      <= port_if.tag_value_pin;
        sw_q.syt     <= '0;
      end
    end
  end

  assign src_ready_out         = ~sink_mode_in & port_if.accept_ready;
  assign sink_valid_out        = sv_q;
  assign sink_word_out         = sw_q;
  assign frame_sync_out        = fso_q;
  assign port_if.clk_app_o     = clk_q;
  assign port_if.clk_app_oe    = clk_oe_q;
  assign port_if.bus_app_o     = d_q;
  assign port_if.bus_app_oe    = ~sink_mode_in;
  assign port_if.vld_app_o     = v_q;
  assign port_if.sop_app_o     = s_q;
  assign port_if.fs_app_o      = fs_q;
  assign port_if.sy_app_o      = sy_q;
  assign port_if.rdy_app_o     = rdy_q;
  assign port_if.packet_end_in = e_q;
endmodule : avsp_app_end

// file: hw/avsp_defines.svh
// Purpose: constants of the application stream port
// Assumes: byte register offsets, 32-bit registers
// Notes:   register bits not named here store but steer nothing
// What this block does
// - direction bit picks transmit or receive, transmit default
// - receiving: crc error flag marks unreliable packet
// - receiving: sequence flag marks lost source packet
// - source drives packet end only for odd lengths
// - all transfers use application clock rising edge
// - clock pin input unless packet control enables drive
// - frame sync input transmitting, output receiving
// - transmitting: timestamp frame sync for header field
// - receiving: frame sync made from header timestamp
// - tag value pin direction, handling by bit 0
// - valid marks each cycle carrying a byte
// - packet start rides with valid on first byte
// - receiving: start held until first byte leaves
// - one byte per transfer, bit 7 most significant
// - ready throttles source with one pipeline stage
`ifndef AVSP_DEFINES_SVH
`define AVSP_DEFINES_SVH
`define AVSP_ADDR_W            8
`define AVSP_OFS_GLOBAL_CTRL   8'h18
`define AVSP_OFS_TX_PKT_CTRL   8'h20
`define AVSP_OFS_TX_CTRL       8'h34
`define AVSP_OFS_RX_PKT_CTRL   8'h40
`define AVSP_OFS_RX_CTRL       8'h54
`define AVSP_REG_RESET         32'h0000_0000
`define AVSP_DIR_BIT           0
`define AVSP_CLK_OE_BIT        0
`define AVSP_SY_EN_BIT         0
`define AVSP_CLK_HALF          4'h1
`define AVSP_STAMP_W           16
`endif

// file: hw/avsp_dev_end.sv
// Purpose: link-side end of the application stream port
// Assumes: registers written on ref_clk_in; pins on av_clk_in
// Notes:   link buffer side is a valid/ready word pair per direction
`timescale 1ns/1ps
`include "avsp_defines.svh"
module avsp_dev_end (
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   av_clk_in,
  avsp_port_if.dev                    port_if,
  input  wire logic [`AVSP_ADDR_W-1:0] reg_addr_in,
  input  wire logic                   reg_wr_in,
  input  wire logic [31:0]            reg_wdata_in,
  output logic [31:0]                 reg_rdata_out,
  output logic                        tx_valid_out,
  output avsp_pkg::avsp_tx_word_t     tx_word_out,
  input  wire logic                   tx_ready_in,
  output logic                        tx_stamp_valid_out,
  output logic [`AVSP_STAMP_W-1:0]    tx_stamp_out,
  input  wire logic                   rx_valid_in,
  input  wire avsp_pkg::avsp_rx_word_t rx_word_in,
  output logic                        rx_ready_out
);
  import avsp_pkg::*;

  function automatic logic [2:0] reg_index(logic [`AVSP_ADDR_W-1:0] a);
    case (a)
      `AVSP_OFS_GLOBAL_CTRL: reg_index = 3'd0;
      `AVSP_OFS_TX_PKT_CTRL: reg_index = 3'd1;
      `AVSP_OFS_TX_CTRL:     reg_index = 3'd2;
      `AVSP_OFS_RX_PKT_CTRL: reg_index = 3'd3;
      `AVSP_OFS_RX_CTRL:     reg_index = 3'd4;
      default:               reg_index = 3'd7;
    endcase
  endfunction : reg_index

  // ---------------- register side, ref_clk_in ----------------
  logic [31:0] regs_q [5];
  logic [31:0] rdata_q;
  logic        clk_q, clk_oe_q;
  logic [3:0]  div_q;
  wire  [2:0]  wr_idx  = reg_index(reg_addr_in);
  wire  [2:0]  rd_idx  = reg_index(reg_addr_in);
  wire         cfg_rx  = regs_q[0][`AVSP_DIR_BIT];
  wire         clk_en  = cfg_rx ? regs_q[3][`AVSP_CLK_OE_BIT]
                                : regs_q[1][`AVSP_CLK_OE_BIT];
  wire         div_end = (div_q == `AVSP_CLK_HALF - 4'h1);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 5; i++) regs_q[i] <= `AVSP_REG_RESET;
    end else if (reg_wr_in && wr_idx != 3'd7) begin
      regs_q[wr_idx] <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q  <= 32'h0000_0000;
      clk_q    <= 1'b0;
      clk_oe_q <= 1'b0;
      div_q    <= 4'h0;
    end else begin
      rdata_q  <= (rd_idx == 3'd7) ? 32'h0000_0000 : regs_q[rd_idx];
      clk_oe_q <= clk_en;
      div_q    <= div_end ? 4'h0 : div_q + 4'h1;
      if (div_end) clk_q <= ~clk_q;
    end
  end

  assign reg_rdata_out      = rdata_q;
  assign port_if.clk_dev_o  = clk_q;
  assign port_if.clk_dev_oe = clk_oe_q;

  // ---------------- link side, av_clk_in ----------------
  // settings are quasi-static, so a two-stage level sync is enough
  logic [2:0] cfg_s1_q, cfg_s2_q;
  wire  [2:0] cfg_raw = {regs_q[4][`AVSP_SY_EN_BIT],
                         regs_q[2][`AVSP_SY_EN_BIT], cfg_rx};
  wire        rx_mode   = cfg_s2_q[0];
  wire        sy_tx_en  = cfg_s2_q[1];
  wire        sy_rx_en  = cfg_s2_q[2];

  logic [`AVSP_STAMP_W-1:0] cyc_q;

  always_ff @(posedge av_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_s1_q <= 3'b000;
      cfg_s2_q <= 3'b000;
      cyc_q    <= '0;
    end else begin
      cfg_s1_q <= cfg_raw;
      cfg_s2_q <= cfg_s1_q;
      cyc_q    <= cyc_q + 1'b1;
    end
  end

  // transmit: two-entry skid absorbs the byte sent as ready drops
  avsp_tx_word_t sk_q [2];
  logic [1:0]    cnt_q;
  logic          rdy_q, fs_prev_q;
  logic          xs_ready, ts_ready;
  avsp_tx_word_t in_word;
  assign in_word.sy   = sy_tx_en & port_if.tag_value_pin;
  assign in_word.eop  = port_if.packet_end_in;
  assign in_word.sop  = port_if.packet_start;
  assign in_word.data = port_if.av_byte_bus;

  wire       push   = ~rx_mode & port_if.byte_valid & (cnt_q != 2'd2);
  wire       pop    = xs_ready & (cnt_q != 2'd0);
  wire [1:0] wr_pos = cnt_q - {1'b0, pop};
  wire [1:0] cnt_d  = cnt_q + {1'b0, push} - {1'b0, pop};
  wire       fs_rise = ~rx_mode & port_if.frame_sync_pin & ~fs_prev_q;

  always_ff @(posedge av_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sk_q[0]   <= '0;
      sk_q[1]   <= '0;
      cnt_q     <= 2'd0;
      rdy_q     <= 1'b0;
      fs_prev_q <= 1'b0;
    end else begin
      if (pop) sk_q[0] <= sk_q[1];
      if (push) sk_q[wr_pos[0]] <= in_word;
      cnt_q     <= cnt_d;
      rdy_q     <= ~rx_mode & (cnt_d == 2'd0);
      fs_prev_q <= port_if.frame_sync_pin;
    end
  end

  avsp_word_xfer #(.W($bits(avsp_tx_word_t))) u_tx_xfer (
    .rst_in        (rst_in),
    .src_clk_in    (av_clk_in),
    .src_valid_in  (cnt_q != 2'd0),
    .src_data_in   (sk_q[0]),
    .src_ready_out (xs_ready),
    .dst_clk_in    (ref_clk_in),
    .dst_valid_out (tx_valid_out),
    .dst_data_out  (tx_word_out),
    .dst_ready_in  (tx_ready_in)
  );

  // a frame mark arriving while the last stamp is in flight is lost
  avsp_word_xfer #(.W(`AVSP_STAMP_W)) u_ts_xfer (
    .rst_in        (rst_in),
    .src_clk_in    (av_clk_in),
    .src_valid_in  (fs_rise),
    .src_data_in   (cyc_q),
    .src_ready_out (ts_ready),
    .dst_clk_in    (ref_clk_in),
    .dst_valid_out (tx_stamp_valid_out),
    .dst_data_out  (tx_stamp_out),
    .dst_ready_in  (1'b1)
  );

  // receive: one held word, sent when the sink's ready is seen
  avsp_rx_word_t hold_w, xr_word;
  logic          hold_q, xr_valid;
  logic [7:0]    d_q;
  logic          v_q, s_q, e0_q, e1_q, sy_q, fs_q, armed_q;
  logic [`AVSP_STAMP_W-1:0] syt_q;

  wire take = rx_mode & hold_q & port_if.accept_ready;

  avsp_word_xfer #(.W($bits(avsp_rx_word_t))) u_rx_xfer (
    .rst_in        (rst_in),
    .src_clk_in    (ref_clk_in),
    .src_valid_in  (rx_valid_in),
    .src_data_in   (rx_word_in),
    .src_ready_out (rx_ready_out),
    .dst_clk_in    (av_clk_in),
    .dst_valid_out (xr_valid),
    .dst_data_out  (xr_word),
    .dst_ready_in  (~hold_q)
  );

  always_ff @(posedge av_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_q <= 1'b0;
      hold_w <= '0;
    end else if (!hold_q && xr_valid) begin
      hold_q <= 1'b1;
      hold_w <= xr_word;
    end else if (take || !rx_mode) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge av_clk_in or posedge rst_in) begin
    if (rst_in) begin
      d_q  <= 8'h00;
      v_q  <= 1'b0;
      s_q  <= 1'b0;
      e0_q <= 1'b0;
      e1_q <= 1'b0;
      sy_q <= 1'b0;
    end else begin
      v_q <= take;
      if (take) begin
        d_q  <= hold_w.data;
        s_q  <= hold_w.sop;
        e0_q <= hold_w.crc_err;
        e1_q <= hold_w.seq_err;
        sy_q <= sy_rx_en & hold_w.sy;
      end else begin
        // start shows as soon as a packet waits, held until it leaves
        s_q  <= rx_mode & hold_q & hold_w.sop;
        e0_q <= 1'b0;
        e1_q <= 1'b0;
      end
    end
  end

  // frame sync fires when the cycle count reaches the packet stamp
  always_ff @(posedge av_clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed_q <= 1'b0;
      syt_q   <= '0;
      fs_q    <= 1'b0;
    end else begin
      fs_q <= rx_mode & armed_q & (cyc_q == syt_q);
      if (take && hold_w.sop) begin
        armed_q <= 1'b1;
        syt_q   <= hold_w.syt;
      end else if (fs_q || !rx_mode) begin
        armed_q <= 1'b0;
      end
    end
  end

  assign port_if.bus_dev_o          = d_q;
  assign port_if.vld_dev_o          = v_q;
  assign port_if.sop_dev_o          = s_q;
  assign port_if.crc_error_flag     = e0_q;
  assign port_if.sequence_loss_flag = e1_q;
  assign port_if.sy_dev_o           = sy_q;
  assign port_if.fs_dev_o           = fs_q;
  assign port_if.rdy_dev_o          = rdy_q;
  assign port_if.bus_dev_oe         = rx_mode;
  assign port_if.err_dev_oe         = rx_mode;
endmodule : avsp_dev_end

// file: hw/avsp_pkg.sv
// Purpose: shared types of the application stream port
// Assumes: avsp_defines.svh holds the numbers
// Notes:   words are what crosses between clock domains
package avsp_pkg;
  typedef enum logic {AVSP_DIR_TX, AVSP_DIR_RX} avsp_dir_t;

  typedef struct packed {
    logic       sy;
    logic       eop;
    logic       sop;
    logic [7:0] data;
  } avsp_tx_word_t;

  typedef struct packed {
    logic [15:0] syt;
    logic        sy;
    logic        seq_err;
    logic        crc_err;
    logic        sop;
    logic [7:0]  data;
  } avsp_rx_word_t;
endpackage : avsp_pkg

// file: hw/avsp_port_if.sv
// Purpose: pins between the link device and the application
// Assumes: each two-way pin has out from each end; ready has no enable, bus_dev_oe picks it
// Notes:   undriven pins read low, as with a pull-down
`timescale 1ns/1ps
interface avsp_port_if;
  logic       clk_dev_o, clk_dev_oe, clk_app_o, clk_app_oe;
  logic [7:0] bus_dev_o, bus_app_o;
  logic       bus_dev_oe, bus_app_oe;
  logic       vld_dev_o, vld_app_o, sop_dev_o, sop_app_o;
  logic       fs_dev_o, fs_app_o, sy_dev_o, sy_app_o;
  logic       rdy_dev_o, rdy_app_o;
  logic       crc_error_flag, sequence_loss_flag, err_dev_oe;
  logic       packet_end_in;
  logic       application_clock_pin;
  logic [7:0] av_byte_bus;
  logic       byte_valid, packet_start, frame_sync_pin;
  logic       tag_value_pin, accept_ready;

  assign application_clock_pin = clk_dev_oe ? clk_dev_o :
                                 clk_app_oe ? clk_app_o : 1'b0;
  assign av_byte_bus    = bus_dev_oe ? bus_dev_o :
                          bus_app_oe ? bus_app_o : 8'h00;
  assign byte_valid     = bus_dev_oe ? vld_dev_o : bus_app_oe & vld_app_o;
  assign packet_start   = bus_dev_oe ? sop_dev_o : bus_app_oe & sop_app_o;
  assign frame_sync_pin = bus_dev_oe ? fs_dev_o : bus_app_oe & fs_app_o;
  assign tag_value_pin  = bus_dev_oe ? sy_dev_o : bus_app_oe & sy_app_o;
  assign accept_ready   = bus_dev_oe ? rdy_app_o : rdy_dev_o;

  modport dev (
    input  application_clock_pin, av_byte_bus, byte_valid, packet_start,
    input  frame_sync_pin, tag_value_pin, accept_ready, packet_end_in,
    output clk_dev_o, clk_dev_oe, bus_dev_o, bus_dev_oe, vld_dev_o,
    output sop_dev_o, fs_dev_o, sy_dev_o, rdy_dev_o,
    output crc_error_flag, sequence_loss_flag, err_dev_oe
  );
  modport app (
    input  application_clock_pin, av_byte_bus, byte_valid, packet_start,
    input  frame_sync_pin, tag_value_pin, accept_ready,
    input  crc_error_flag, sequence_loss_flag,
    output clk_app_o, clk_app_oe, bus_app_o, bus_app_oe, vld_app_o,
    output sop_app_o, fs_app_o, sy_app_o, rdy_app_o, packet_end_in
  );
endinterface : avsp_port_if

// file: hw/avsp_word_xfer.sv
// Purpose: moves one word at a time between two clock domains
// Assumes: one reset, asynchronous, shared by both domains
// Notes:   toggle handshake; data is held still until acknowledged
`timescale 1ns/1ps
module avsp_word_xfer #(
  parameter int W = 8
) (
  input  wire logic         rst_in,
  input  wire logic         src_clk_in,
  input  wire logic         src_valid_in,
  input  wire logic [W-1:0] src_data_in,
  output logic              src_ready_out,
  input  wire logic         dst_clk_in,
  output logic              dst_valid_out,
  output logic [W-1:0]      dst_data_out,
  input  wire logic         dst_ready_in
);
  logic         req_q, ack_q;
  logic [1:0]   ack_sync_q, req_sync_q;
  logic [W-1:0] data_q;

  always_ff @(posedge src_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_q      <= 1'b0;
      data_q     <= '0;
      ack_sync_q <= 2'b00;
    end else begin
      ack_sync_q <= {ack_sync_q[0], ack_q};
      if (src_ready_out && src_valid_in) begin
        req_q  <= ~req_q;
        data_q <= src_data_in;
      end
    end
  end

  always_ff @(posedge dst_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_sync_q <= 2'b00;
      ack_q      <= 1'b0;
    end else begin
      req_sync_q <= {req_sync_q[0], req_q};
      if (dst_valid_out && dst_ready_in) ack_q <= ~ack_q;
    end
  end

  assign src_ready_out = (req_q == ack_sync_q[1]);
  assign dst_valid_out = (req_sync_q[1] != ack_q);
  assign dst_data_out  = data_q;
endmodule : avsp_word_xfer

// file: verif/av_stream_port_tb.sv
// Purpose: both stream port ends joined, driven and compared
// Assumes: application clock first made by the application divider
// Notes:   frame sync is checked against the free-running cycle count
`timescale 1ns/1ps
module av_stream_port_tb;
  import avsp_pkg::*;
  logic          ref_clk_in, rst_in, reg_wr, tx_valid, tx_ready;
  logic          stamp_valid, rx_valid, rx_ready, clk_drive, sink_mode;
  logic          src_valid, src_ready, frame_mark, sink_valid, sink_ready;
  logic          fsync;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata;
  logic [15:0]   stamp, due;
  avsp_tx_word_t tx_word, src_word, w;
  avsp_rx_word_t rx_word, sink_word, r;
  avsp_tx_word_t tx_q[$], tx_exp[$];
  avsp_rx_word_t rx_q[$], rx_exp[$];
  int            fail_count, check_count, cyc, stamp_n, av_n, n, fs_n, fs_at;
  logic [7:0]    ofs [5] = '{8'h18, 8'h20, 8'h34, 8'h40, 8'h54};
  wire logic     av_clk;

  avsp_port_if port_if ();
  assign av_clk = port_if.application_clock_pin;

  avsp_dev_end u_avsp_dev_end (.ref_clk_in, .rst_in, .av_clk_in(av_clk),
    .port_if(port_if), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .tx_valid_out(tx_valid), .tx_word_out(tx_word), .tx_ready_in(tx_ready),
    .tx_stamp_valid_out(stamp_valid), .tx_stamp_out(stamp),
    .rx_valid_in(rx_valid), .rx_word_in(rx_word), .rx_ready_out(rx_ready));
  avsp_app_end u_avsp_app_end (.ref_clk_in, .rst_in, .av_clk_in(av_clk),
    .port_if(port_if), .clk_drive_in(clk_drive), .sink_mode_in(sink_mode),
    .src_valid_in(src_valid), .src_word_in(src_word),
    .src_ready_out(src_ready), .frame_mark_in(frame_mark),
    .sink_valid_out(sink_valid), .sink_word_out(sink_word),
    .sink_ready_in(sink_ready), .frame_sync_out(fsync));
  avsp_port_props u_avsp_port_props (
    .application_clock_pin(port_if.application_clock_pin), .rst_in,
    .bus_dev_oe(port_if.bus_dev_oe), .byte_valid(port_if.byte_valid),
    .packet_start(port_if.packet_start), .accept_ready(port_if.accept_ready),
    .crc_error_flag(port_if.crc_error_flag),
    .sequence_loss_flag(port_if.sequence_loss_flag));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge ref_clk_in);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_in);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check(reg_rdata, exp);
  endtask : reg_read

  // request held until the edge where ready was seen high
  task automatic send_byte(input avsp_tx_word_t b);
    logic ok;
    @(posedge av_clk);
    src_valid <= 1'b1;
    src_word <= b;
    do begin
      @(negedge av_clk);
      ok = src_ready;
      @(posedge av_clk);
    end while (ok !== 1'b1);
    src_valid <= 1'b0;
  endtask : send_byte

  task automatic send_rx(input avsp_rx_word_t b);
    logic ok;
    @(posedge ref_clk_in);
    rx_valid <= 1'b1;
    rx_word <= b;
    do begin
      @(negedge ref_clk_in);
      ok = rx_ready;
      @(posedge ref_clk_in);
    end while (ok !== 1'b1);
    rx_valid <= 1'b0;
  endtask : send_rx

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  always @(negedge ref_clk_in) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) tx_q.push_back(tx_word);
    if (stamp_valid === 1'b1) stamp_n++;
  end
  always @(negedge av_clk) begin
    if (sink_valid === 1'b1) rx_q.push_back(sink_word);
    if (fsync === 1'b1) begin
      fs_n++;
      fs_at = av_n;
    end
  end
  always @(posedge av_clk) av_n++;
  // ceiling well above the thousand-odd cycles the sequence needs
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    // scheduled so every reset process is already waiting for the edge
    rst_in <= 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 32'h0000_0000;
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_word = '0;
    clk_drive = 1'b1;
    sink_mode = 1'b0;
    src_valid = 1'b0;
    src_word = '0;
    frame_mark = 1'b0;
    sink_ready = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    foreach (ofs[i]) reg_read(ofs[i], 32'h0000_0000);
    check(32'(port_if.bus_dev_oe), 32'h0000_0000);
    foreach (ofs[i]) begin
      reg_write(ofs[i], 32'hA5A5_5A5A);
      reg_read(ofs[i], 32'hA5A5_5A5A);
    end
    reg_write(8'h1C, 32'hFFFF_FFFF);
    reg_read(8'h1C, 32'h0000_0000);
    for (int m = 0; m < 2; m++) begin
      reg_write(8'h34, 32'(m));
      repeat (10) @(posedge ref_clk_in);
      for (int i = 0; i < 5 - m; i++) begin
        w.data = 8'h3C ^ 8'(i * 37);
        w.sop = (i == 0);
        w.eop = (m == 0 && i == 4);
        w.sy = i[0];
        send_byte(w);
        w.sy = w.sy & m[0];
        tx_exp.push_back(w);
      end
    end
    @(posedge av_clk) frame_mark <= 1'b1;
    @(negedge av_clk) n = av_n;
    repeat (4) @(posedge av_clk);
    frame_mark <= 1'b0;
    repeat (40) @(posedge ref_clk_in);
    check(32'(stamp_n), 32'h0000_0001);
    check(32'(stamp), 32'(n + 1));
    check(32'(tx_q.size()), 32'h0000_0009);
    while (tx_q.size() > 0 && tx_exp.size() > 0)
      check(32'(tx_q.pop_front()), 32'(tx_exp.pop_front()));
    reg_write(8'h18, 32'h0000_0001);
    reg_write(8'h54, 32'h0000_0001);
    @(posedge av_clk);
    sink_mode <= 1'b1;
    sink_ready <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    check(32'(port_if.bus_dev_oe), 32'h0000_0001);
    due = 16'(av_n + 400);
    for (int i = 0; i < 5; i++) begin
      r = '0;
      r.data = 8'hC0 + 8'(i);
      r.sop = (i == 0 || i == 4);
      r.crc_err = (i == 1);
      r.seq_err = (i == 2);
      r.sy = (i == 3);
      r.syt = due;
      if (i == 4) begin
        repeat (40) @(posedge ref_clk_in);
        @(posedge av_clk) sink_ready <= 1'b0;
      end
      send_rx(r);
      r.syt = 16'h0000;
      rx_exp.push_back(r);
    end
    repeat (40) @(posedge ref_clk_in);
    check(32'(rx_q.size()), 32'h0000_0004);
    @(posedge av_clk) sink_ready <= 1'b1;
    repeat (40) @(posedge ref_clk_in);
    check(32'(rx_q.size()), 32'h0000_0005);
    while (rx_q.size() > 0 && rx_exp.size() > 0)
      check(32'(rx_q.pop_front()), 32'(rx_exp.pop_front()));
    reg_write(8'h40, 32'h0000_0001);
    repeat (10) @(posedge ref_clk_in);
    clk_drive <= 1'b0;
    repeat (10) @(posedge ref_clk_in);
    n = av_n;
    repeat (40) @(posedge ref_clk_in);
    check(32'(port_if.clk_dev_oe), 32'h0000_0001);
    check(32'(av_n - n >= 19 && av_n - n <= 21), 32'h0000_0001);
    // counter equals stamp one edge, pin one later, sink flop one more
    repeat (800) @(posedge ref_clk_in);
    check(32'(fs_n), 32'h0000_0001);
    check(32'(fs_at), 32'(due) + 32'h0000_0002);
    report_and_stop();
  end
endmodule : av_stream_port_tb

// file: verif/avsp_port_props.sv
// Purpose: pin-level checks between the two stream port ends
// Assumes: application clock pin clocks the pins, rst_in resets
// Notes:   bus_dev_oe high means the device is the byte source
`timescale 1ns/1ps
module avsp_port_props (
  input wire logic application_clock_pin,
  input wire logic rst_in,
  input wire logic bus_dev_oe,
  input wire logic byte_valid,
  input wire logic packet_start,
  input wire logic accept_ready,
  input wire logic crc_error_flag,
  input wire logic sequence_loss_flag
);
  default clocking cb @(posedge application_clock_pin); endclocking
  default disable iff (rst_in);

  property p_dev_valid_pulse;
    bus_dev_oe && byte_valid |=> !byte_valid;
  endproperty
  property p_start_hold;
    bus_dev_oe && packet_start && !byte_valid |=> packet_start || !bus_dev_oe;
  endproperty
  property p_start_once;
    bus_dev_oe && packet_start && byte_valid |=> !packet_start;
  endproperty
  // ready is pipelined once, so valid may only follow a sampled ready
  property p_dev_waits;
    bus_dev_oe && byte_valid |-> $past(accept_ready);
  endproperty
  property p_app_waits;
    !bus_dev_oe && byte_valid |-> $past(accept_ready);
  endproperty
  property p_dev_ready_drop;
    !bus_dev_oe && byte_valid |=> !accept_ready;
  endproperty
  property p_sop_valid;
    !bus_dev_oe && packet_start |-> byte_valid;
  endproperty
  property p_crc_valid;
    crc_error_flag |-> bus_dev_oe && byte_valid;
  endproperty
  property p_seq_valid;
    sequence_loss_flag |-> bus_dev_oe && byte_valid;
  endproperty

  a_dev_valid_pulse: assert property (p_dev_valid_pulse)
    else $error("device valid held past one cycle");
  a_start_hold: assert property (p_start_hold)
    else $error("packet start dropped before first byte");
  a_start_once: assert property (p_start_once)
    else $error("packet start outlived its valid byte");
  a_dev_waits: assert property (p_dev_waits)
    else $error("device sent a byte without ready");
  a_app_waits: assert property (p_app_waits)
    else $error("application sent a byte without ready");
  a_dev_ready_drop: assert property (p_dev_ready_drop)
    else $error("device ready stayed high after a byte");
  a_sop_valid: assert property (p_sop_valid)
    else $error("source start without valid");
  a_crc_valid: assert property (p_crc_valid)
    else $error("crc flag outside a delivered byte");
  a_seq_valid: assert property (p_seq_valid)
    else $error("sequence flag outside a delivered byte");

  c_rx_start: cover property (bus_dev_oe && byte_valid && packet_start);
  c_tx_byte: cover property (!bus_dev_oe && byte_valid);
  c_held: cover property (bus_dev_oe && packet_start ##1 packet_start[*2]);
  c_crc: cover property (crc_error_flag);
endmodule : avsp_port_props
